// File: src/qla_pkg.sv
// Constants, register map and types of the quad link input mode aggregator
package qla_pkg;
   localparam int NUM_PORTS = 4;
   localparam int CSI_FRAME_W = 40;
   localparam int RAW_FRAME_W = 28;
   localparam int OUT_W = 40;
   localparam int FIFO_DEPTH = 16;

   // Register offsets
   localparam logic [7:0] ADDR_PORT_SELECT = 8'h4C;
   localparam logic [7:0] ADDR_BACK_CHANNEL_CONFIG = 8'h58;
   localparam logic [7:0] ADDR_PORT_CONFIGURATION = 8'h6D;
   localparam logic [7:0] ADDR_RAW_HEADER = 8'h70;
   localparam logic [7:0] ADDR_VC_REMAP = 8'h71;
   localparam logic [7:0] ADDR_PORT_STATUS = 8'h72;

   // Field positions
   localparam int MODE_LSB = 0;
   localparam int RAW8_BIT = 2;
   localparam int BC_SEL_LSB = 0;
   localparam int HDR_DT_LSB = 0;
   localparam int HDR_VC_LSB = 6;

   // Input mode field codes
   typedef enum logic [1:0] {
      QLA_MODE_CSI = 2'h0,
      QLA_MODE_RAW12_LF = 2'h1,
      QLA_MODE_RAW12_HF = 2'h2,
      QLA_MODE_RAW10 = 2'h3
   } qla_mode_e;

   // Back channel rate select codes
   localparam logic [2:0] BC_SEL_2M5 = 3'h0;
   localparam logic [2:0] BC_SEL_10M = 3'h2;
   localparam logic [2:0] BC_SEL_50M = 3'h6;

   // Reset values
   localparam logic [7:0] RST_VC_REMAP = 8'hE4;
   localparam logic [7:0] RST_RAW_HEADER = 8'h00;
   localparam logic [1:0] RST_PORT_SELECT = 2'h0;

   // Rates and cycle counts
   localparam longint CLK_HZ = 50_000_000;
   localparam longint BC_RATE_2M5_BPS = 2_500_000;
   localparam longint BC_RATE_10M_BPS = 10_000_000;
   localparam longint BC_RATE_50M_BPS = 50_000_000;
   localparam int BC_DIV_2M5 = int'(CLK_HZ / BC_RATE_2M5_BPS);
   localparam int BC_DIV_10M = int'(CLK_HZ / BC_RATE_10M_BPS);
   localparam int BC_DIV_50M = int'(CLK_HZ / BC_RATE_50M_BPS);
   localparam int SYNC_GAP_PCLK = 10;
   localparam int STRAP_SETTLE_CYCLES = 2;

   // Link rate ratios against the reference clock
   localparam int SYNC_LINE_MULT = 160;
   localparam int SYNC_PCLK_MULT = 4;
   localparam int SYNC_BC_MULT = 2;
   localparam int NONSYNC_LINE_MULT = 80;
   localparam int RAW_LINE_MULT = 28;
   localparam longint MAX_CSI_LINE_BPS = 64'hF7F4_9000;

   // Default RAW data types
   localparam logic [5:0] DT_RAW8 = 6'h2A;
   localparam logic [5:0] DT_RAW10 = 6'h2B;
   localparam logic [5:0] DT_RAW12 = 6'h2C;
endpackage

// File: src/qla_fifo.sv
// Parameterised valid/ready FIFO in flip-flops
`timescale 1ns/10ps
module qla_fifo #(
   parameter int WIDTH = 42,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   if (DEPTH < 2 || (1 << AW) != DEPTH)
   begin : g_bad_depth
      $error("qla_fifo: DEPTH must be a power of two of at least 2");
   end

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge ref_clk)
   begin
      if (push)
         mem_q[wr_q] <= in_data;
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
            wr_q <= wr_q + 1'b1;
         if (pop)
            rd_q <= rd_q + 1'b1;
         if (push && !pop)
            cnt_q <= cnt_q + 1'b1;
         else if (pop && !push)
            cnt_q <= cnt_q - 1'b1;
      end
   end
endmodule

// File: src/qla_aggregator.sv
// Four-port input mode logic, header rewrite and stream aggregation
// Operation
// - Each port takes its input mode from a two-bit field of port_configuration.
// - The mode strap pin may choose the input mode instead of software.
// - Packetized ports accept 40-bit frames with payload and header information.
// - RAW ports accept 28-bit frames at a lower line rate.
// - Synchronous packetized: line 160x, pixel clock 4x, back channel 2x reference.
// - Non-synchronous packetized: line 80x serializer clock, pixel 2x or 1x.
// - Packetized ports accept line rates up to 4.16 Gbps.
// - Forward line rate is independent of the output rate.
// - Packetized ports remap incoming virtual channel numbers at their input.
// - RAW ports insert programmable virtual channel and data type in headers.
// - RAW 8, 10 or 12-bit pixels become matching RAW output streams.
// - RAW12 high frequency: 12 data plus 2 sync bits, 37.5-100 MHz.
// - RAW12 low frequency: 12 data plus 2 sync bits, 25-50 MHz.
// - RAW10: 10 data plus 2 sync bits, 50-100 MHz pixel clock.
// - All output leaves as one packet stream through one port.
// - Streams from any port are forwarded onto the single output.
// - Streams interleave as virtual channels with unique numbers in headers.
// - YUV formats with RAW packing pass with YUV data types.
// - The control register port runs continuously, independent of video blanking.
// - Back channel defaults: 50 Mbps packetized synchronous, 2.5 Mbps RAW.
`timescale 1ns/10ps
module qla_aggregator
   import qla_pkg::*;
#(
   parameter int FIFO_WORDS = qla_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Mode strap, level index 0..7
   input wire logic [2:0] mode_strap,
   // Control register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Receive ports, deserialized frames
   input wire logic [qla_pkg::NUM_PORTS-1:0] rx_valid,
   output logic [qla_pkg::NUM_PORTS-1:0] rx_ready,
   input wire logic [qla_pkg::NUM_PORTS-1:0][qla_pkg::CSI_FRAME_W-1:0] rx_frame,
   // Back channel bit rate enables
   output logic [qla_pkg::NUM_PORTS-1:0] bc_tick,
   // Aggregated output stream
   output logic out_valid,
   input wire logic out_ready,
   output logic [1:0] out_vc,
   output logic [5:0] out_dt,
   output logic [31:0] out_data,
   output logic [1:0] out_port
);
   import qla_pkg::*;

   localparam int NP = NUM_PORTS;
   localparam int FW = OUT_W + 2;

   if (FIFO_WORDS < 2)
   begin : g_bad_words
      $error("qla_aggregator: FIFO_WORDS must be at least 2");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Strap capture

   logic [2:0] strap_s1_q;
   logic [2:0] strap_s2_q;
   logic [1:0] settle_q;
   logic strap_load;
   logic strap_done_q;
   qla_mode_e strap_mode;
   logic strap_sync_csi;

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         strap_s1_q <= '0;
         strap_s2_q <= '0;
      end
      else
      begin
         strap_s1_q <= mode_strap;
         strap_s2_q <= strap_s1_q;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         settle_q <= '0;
         strap_done_q <= 1'b0;
      end
      else
      begin
         if (!strap_done_q && settle_q != 2'(STRAP_SETTLE_CYCLES))
            settle_q <= settle_q + 1'b1;
         if (strap_load)
            strap_done_q <= 1'b1;
      end
   end

   // One load, after the synchroniser has filled
   assign strap_load = !strap_done_q && settle_q == 2'(STRAP_SETTLE_CYCLES);

   // Index 0/4 packetized, 1/5 RAW12 LF, 2/6 RAW12 HF, 3/7 RAW10
   always_comb
   begin
      strap_sync_csi = (strap_s2_q == 3'h4);
      case (strap_s2_q[1:0])
         2'h0: strap_mode = QLA_MODE_CSI;
         2'h1: strap_mode = QLA_MODE_RAW12_LF;
         2'h2: strap_mode = QLA_MODE_RAW12_HF;
         default: strap_mode = QLA_MODE_RAW10;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   logic [1:0] sel_q;
   logic [NP-1:0][1:0] mode_q;
   logic [NP-1:0] raw8_q;
   logic [NP-1:0][2:0] bc_sel_q;
   logic [NP-1:0][7:0] hdr_q;
   logic [NP-1:0][7:0] remap_q;
   logic [NP-1:0] sync_err_q;
   logic [NP-1:0] sync_err_set;
   logic wr_sel;

   assign wr_sel = reg_wr && reg_addr == ADDR_PORT_SELECT;

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         sel_q <= RST_PORT_SELECT;
      else if (wr_sel)
         sel_q <= reg_wdata[1:0];
   end

   // Writes accepted in any cycle but the strap load cycle, no dependence on stream state
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         mode_q <= '0;
         raw8_q <= '0;
         bc_sel_q <= '0;
         hdr_q <= '0;
         remap_q <= '0;
      end
      else
      begin
         for (int p = 0; p < NP; p++)
         begin
            if (strap_load)
            begin
               mode_q[p] <= strap_mode;
               if (strap_mode == QLA_MODE_CSI && strap_sync_csi)
                  bc_sel_q[p] <= BC_SEL_50M;
               else if (strap_mode == QLA_MODE_CSI)
                  bc_sel_q[p] <= BC_SEL_10M;
               else
                  bc_sel_q[p] <= BC_SEL_2M5;
               hdr_q[p] <= RST_RAW_HEADER;
               remap_q[p] <= RST_VC_REMAP;
            end
            else if (reg_wr && sel_q == 2'(p))
            begin
               case (reg_addr)
                  ADDR_PORT_CONFIGURATION:
                  begin
                     mode_q[p] <= reg_wdata[MODE_LSB +: 2];
                     raw8_q[p] <= reg_wdata[RAW8_BIT];
                  end
                  ADDR_BACK_CHANNEL_CONFIG: bc_sel_q[p] <= reg_wdata[BC_SEL_LSB +: 3];
                  ADDR_RAW_HEADER: hdr_q[p] <= reg_wdata;
                  ADDR_VC_REMAP: remap_q[p] <= reg_wdata;
                  default: ;
               endcase
            end
         end
      end
   end

   // Sync spacing flag, write one to clear, a new event wins
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         sync_err_q <= '0;
      else
      begin
         for (int p = 0; p < NP; p++)
         begin
            if (sync_err_set[p])
               sync_err_q[p] <= 1'b1;
            else if (reg_wr && reg_addr == ADDR_PORT_STATUS && reg_wdata[p])
               sync_err_q[p] <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         reg_rdata <= '0;
      else if (reg_rd)
      begin
         case (reg_addr)
            ADDR_PORT_SELECT: reg_rdata <= {6'h00, sel_q};
            ADDR_PORT_CONFIGURATION: reg_rdata <= {5'h00, raw8_q[sel_q], mode_q[sel_q]};
            ADDR_BACK_CHANNEL_CONFIG: reg_rdata <= {5'h00, bc_sel_q[sel_q]};
            ADDR_RAW_HEADER: reg_rdata <= hdr_q[sel_q];
            ADDR_VC_REMAP: reg_rdata <= remap_q[sel_q];
            ADDR_PORT_STATUS: reg_rdata <= {strap_done_q, 3'h0, sync_err_q};
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-port back channel dividers and frame translation

   logic [NP-1:0][FW-1:0] word;
   logic [NP-1:0][4:0] bc_cnt_q;
   logic [NP-1:0][4:0] bc_div;
   logic [NP-1:0][1:0] sync_prev_q;
   logic [NP-1:0][3:0] gap_q;

   for (genvar p = 0; p < NP; p++)
   begin : g_port
      logic is_raw;
      logic [1:0] sync_in;
      logic [11:0] pix;
      logic [1:0] vc_in;
      logic [5:0] dt_def;
      logic [5:0] dt_raw;
      logic [31:0] data;
      logic [1:0] vc;
      logic [5:0] dt;

      assign is_raw = mode_q[p] != QLA_MODE_CSI;
      assign sync_in = rx_frame[p][13:12];
      assign vc_in = rx_frame[p][39:38];

      // Back channel bit period from the selected rate
      always_comb
      begin
         case (bc_sel_q[p])
            BC_SEL_50M: bc_div[p] = 5'(BC_DIV_50M);
            BC_SEL_10M: bc_div[p] = 5'(BC_DIV_10M);
            default: bc_div[p] = 5'(BC_DIV_2M5);
         endcase
      end

      always_ff @(posedge ref_clk or negedge rstn)
      begin
         if (!rstn)
            bc_cnt_q[p] <= '0;
         else if (bc_cnt_q[p] >= bc_div[p] - 5'h01)
            bc_cnt_q[p] <= '0;
         else
            bc_cnt_q[p] <= bc_cnt_q[p] + 5'h01;
      end
      assign bc_tick[p] = (bc_cnt_q[p] == '0);

      // RAW pixel width: 12 for both RAW12 modes, 10, or 8 on request
      always_comb
      begin
         pix = rx_frame[p][11:0];
         dt_def = DT_RAW12;
         if (raw8_q[p])
         begin
            pix = {4'h0, rx_frame[p][7:0]};
            dt_def = DT_RAW8;
         end
         else if (mode_q[p] == QLA_MODE_RAW10)
         begin
            pix = {2'h0, rx_frame[p][9:0]};
            dt_def = DT_RAW10;
         end
      end

      // Programmed type overrides the default, including YUV codes
      assign dt_raw = (hdr_q[p][HDR_DT_LSB +: 6] == 6'h00) ? dt_def :
                      hdr_q[p][HDR_DT_LSB +: 6];

      // 40-bit frame: vc, type, payload; 28-bit frame: sync and pixel
      always_comb
      begin
         if (is_raw)
         begin
            vc = hdr_q[p][HDR_VC_LSB +: 2];
            dt = dt_raw;
            data = {18'h00000, sync_in, pix};
         end
         else
         begin
            vc = remap_q[p][{vc_in, 1'b0} +: 2];
            dt = rx_frame[p][37:32];
            data = rx_frame[p][31:0];
         end
      end
      assign word[p] = {2'(p), vc, dt, data};

      // RAW10 sync spacing watch, counted in pixels
      always_ff @(posedge ref_clk or negedge rstn)
      begin
         if (!rstn)
         begin
            sync_prev_q[p] <= '0;
            gap_q[p] <= 4'(SYNC_GAP_PCLK - 1);
         end
         else if (rx_valid[p] && rx_ready[p] && is_raw)
         begin
            sync_prev_q[p] <= sync_in;
            if (sync_in != sync_prev_q[p])
               gap_q[p] <= '0;
            else if (gap_q[p] != 4'(SYNC_GAP_PCLK - 1))
               gap_q[p] <= gap_q[p] + 4'h1;
         end
      end
      assign sync_err_set[p] = rx_valid[p] && rx_ready[p] && mode_q[p] == QLA_MODE_RAW10 &&
                               sync_in != sync_prev_q[p] &&
                               gap_q[p] != 4'(SYNC_GAP_PCLK - 1);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Round-robin forwarding onto the single output

   logic [1:0] rr_q;
   logic [1:0] grant;
   logic any_valid;
   logic fifo_in_ready;
   logic fifo_push;
   logic [FW-1:0] fifo_out;

   always_comb
   begin
      grant = rr_q;
      any_valid = 1'b0;
      for (int i = NP - 1; i >= 0; i--)
      begin
         if (rx_valid[2'(rr_q + 2'(i))])
         begin
            grant = 2'(rr_q + 2'(i));
            any_valid = 1'b1;
         end
      end
   end

   always_comb
   begin
      rx_ready = '0;
      rx_ready[grant] = fifo_in_ready && any_valid;
   end
   assign fifo_push = any_valid && fifo_in_ready;

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         rr_q <= '0;
      else if (fifo_push)
         rr_q <= grant + 2'h1;
   end

   qla_fifo #(
      .WIDTH(FW),
      .DEPTH(FIFO_WORDS)
   ) u_fifo (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .in_valid(fifo_push),
      .in_ready(fifo_in_ready),
      .in_data(word[grant]),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(fifo_out)
   );

   assign {out_port, out_vc, out_dt, out_data} = fifo_out;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   mode_write_a: assert property (reg_wr && !strap_load && reg_addr == ADDR_PORT_CONFIGURATION
      |=> mode_q[$past(sel_q)] == $past(reg_wdata[1:0]))
      else $error("mode field not written");
   strap_load_a: assert property (strap_load |=> mode_q[0] == $past(strap_mode)
      && !strap_load)
      else $error("strap not loaded once");
   bc_default_a: assert property (strap_load && strap_mode != QLA_MODE_CSI
      |=> bc_sel_q[0] == BC_SEL_2M5)
      else $error("RAW back channel default wrong");
   bc_tick_a: assert property (bc_sel_q[0] == BC_SEL_10M && bc_tick[0] && $stable(bc_sel_q[0])
      |=> (!bc_tick[0] || bc_sel_q[0] != BC_SEL_10M) [*4]
      ##1 (bc_tick[0] || bc_sel_q[0] != BC_SEL_10M))
      else $error("10 Mbps divider period wrong");
   remap_a: assert property (fifo_push && mode_q[grant] == QLA_MODE_CSI
      |-> word[grant][39:38] == remap_q[grant][{rx_frame[grant][39:38], 1'b0} +: 2])
      else $error("virtual channel remap wrong");
   raw_hdr_a: assert property (fifo_push && mode_q[grant] != QLA_MODE_CSI
      |-> word[grant][39:38] == hdr_q[grant][7:6])
      else $error("RAW virtual channel not inserted");
   raw10_dt_a: assert property (fifo_push && mode_q[grant] == QLA_MODE_RAW10 && !raw8_q[grant]
      && hdr_q[grant][5:0] == 6'h00 |-> word[grant][37:32] == DT_RAW10)
      else $error("RAW10 data type wrong");
   one_grant_a: assert property ($onehot0(rx_ready))
      else $error("more than one port granted");
   sync_err_a: assert property (sync_err_set[0] |=> sync_err_q[0])
      else $error("sync spacing event lost");
   rr_fair_a: assert property (fifo_push && rx_valid[grant + 2'h1]
      |=> rx_ready[$past(grant) + 2'h1] || !fifo_in_ready)
      else $error("round robin skipped a port");

   raw_pass_c: cover property (fifo_push && mode_q[grant] == QLA_MODE_RAW12_HF);
   csi_pass_c: cover property (out_valid && out_ready && out_vc != 2'h0);
   fifo_full_c: cover property (!fifo_in_ready ##1 out_ready);
   sync_err_c: cover property (sync_err_set != '0);
endmodule

// File: dv/qla_far_side.sv
// Far-side model: four link serializers and the packet stream sink
`timescale 1ns/10ps
module qla_far_side (
   // Clock
   input wire logic ref_clk,
   // Serializer side
   output logic [qla_pkg::NUM_PORTS-1:0] rx_valid,
   input wire logic [qla_pkg::NUM_PORTS-1:0] rx_ready,
   output logic [qla_pkg::NUM_PORTS-1:0][qla_pkg::CSI_FRAME_W-1:0] rx_frame,
   // Sink side
   input wire logic out_valid,
   output logic out_ready,
   input wire logic [1:0] out_vc,
   input wire logic [5:0] out_dt,
   input wire logic [31:0] out_data,
   input wire logic [1:0] out_port
);
   import qla_pkg::*;
   logic stall_q;
   logic slow_q;
   logic timeout_q;
   logic [41:0] got_q[$];

   initial
   begin
      rx_valid = '0;
      rx_frame = '0;
      out_ready = 1'b0;
      stall_q = 1'b1;
      slow_q = 1'b0;
      timeout_q = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sink may refuse or accept every other cycle
   always @(negedge ref_clk)
      out_ready <= !stall_q && !(slow_q && out_ready);

   always @(posedge ref_clk)
      if (out_valid === 1'b1 && out_ready === 1'b1)
         got_q.push_back({out_port, out_vc, out_dt, out_data});

   ////////////////////////////////////////////////////////////////////////////
   // Frame held until taken, then line shows the inverse
   task automatic send(input int p, input logic [39:0] f);
      int n;
      @(negedge ref_clk);
      rx_frame[p] = f;
      rx_valid[p] = 1'b1;
      #1;
      n = 0;
      while (rx_ready[p] !== 1'b1 && n < 300)
      begin
         @(negedge ref_clk);
         #1;
         n++;
      end
      if (n >= 300)
         timeout_q = 1'b1;
      @(negedge ref_clk);
      rx_valid[p] = 1'b0;
      rx_frame[p] = ~f;
   endtask
endmodule

// File: dv/quad_link_input_mode_aggregator_test.sv
// Self-checking testbench of the quad link input mode aggregator
`timescale 1ns/10ps
module quad_link_input_mode_aggregator_test;
   import qla_pkg::*;
   logic ref_clk;
   logic rstn;
   logic reg_wr;
   logic reg_rd;
   logic [2:0] mode_strap;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic [NUM_PORTS-1:0] rx_valid;
   logic [NUM_PORTS-1:0] rx_ready;
   logic [NUM_PORTS-1:0][CSI_FRAME_W-1:0] rx_frame;
   logic [NUM_PORTS-1:0] bc_tick;
   logic out_valid;
   logic out_ready;
   logic [1:0] out_vc;
   logic [5:0] out_dt;
   logic [31:0] out_data;
   logic [1:0] out_port;
   int err_count = 0;
   int samples_checked = 0;
   logic [7:0] modes[4] = '{8'h01, 8'h02, 8'h03, 8'h05};
   logic [5:0] dts[4] = '{DT_RAW12, DT_RAW12, DT_RAW10, DT_RAW8};
   logic [31:0] masks[4] = '{32'hFFF, 32'hFFF, 32'h3FF, 32'hFF};

   qla_aggregator u_qla_aggregator (.ref_clk(ref_clk), .rstn(rstn), .mode_strap(mode_strap),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_frame(rx_frame),
      .bc_tick(bc_tick), .out_valid(out_valid), .out_ready(out_ready), .out_vc(out_vc),
      .out_dt(out_dt), .out_data(out_data), .out_port(out_port));
   qla_far_side u_qla_far_side (.ref_clk(ref_clk), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .rx_frame(rx_frame), .out_valid(out_valid), .out_ready(out_ready), .out_vc(out_vc),
      .out_dt(out_dt), .out_data(out_data), .out_port(out_port));

   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [41:0] got, input logic [41:0] exp, input string what);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic guard();
      if (u_qla_far_side.timeout_q === 1'b1)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: wait ran out", $time);
         end_sim();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      chk({34'h0, reg_rdata & m}, {34'h0, e}, "register read");
   endtask

   task automatic tick_chk(input int p, input int div);
      int n;
      n = 0;
      repeat (100)
      begin
         @(negedge ref_clk);
         if (bc_tick[p] === 1'b1)
            n++;
      end
      chk(42'(n), 42'(100 / div), "back channel tick count");
   endtask

   task automatic send(input int p, input logic [39:0] f);
      u_qla_far_side.send(p, f);
      guard();
   endtask

   task automatic exp_word(input logic [41:0] e);
      int n;
      n = 0;
      while (u_qla_far_side.got_q.size() == 0 && n < 300)
      begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= 300)
         u_qla_far_side.timeout_q = 1'b1;
      guard();
      chk(u_qla_far_side.got_q.pop_front(), e, "output word");
   endtask

   task automatic do_reset(input logic [2:0] s);
      rstn = 1'b0;
      mode_strap = s;
      repeat (16) @(negedge ref_clk);
      chk({38'h0, out_valid, reg_rdata == 8'h00, rx_ready == '0, bc_tick == '1}, 42'h7,
         "reset outputs");
      rstn = 1'b1;
      repeat (6) @(negedge ref_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      rstn = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      mode_strap = 3'h4;
      do_reset(3'h4);
      rd_chk(ADDR_PORT_CONFIGURATION, 8'h00, 8'h03);
      rd_chk(ADDR_BACK_CHANNEL_CONFIG, {5'h0, BC_SEL_50M}, 8'h07);
      rd_chk(ADDR_VC_REMAP, RST_VC_REMAP, 8'hFF);
      rd_chk(ADDR_RAW_HEADER, RST_RAW_HEADER, 8'hFF);
      rd_chk(ADDR_PORT_STATUS, 8'h80, 8'h80);
      tick_chk(0, BC_DIV_50M);
      wr(8'h10, 8'h5A);
      rd_chk(8'h10, 8'h00, 8'hFF);
      wr(ADDR_BACK_CHANNEL_CONFIG, {5'h0, BC_SEL_10M});
      tick_chk(0, BC_DIV_10M);
      wr(ADDR_BACK_CHANNEL_CONFIG, {5'h0, BC_SEL_2M5});
      tick_chk(0, BC_DIV_2M5);
      tick_chk(3, BC_DIV_50M);
      // Port 1 reverses channel numbers
      wr(ADDR_PORT_SELECT, 8'h01);
      wr(ADDR_VC_REMAP, 8'h1B);
      rd_chk(ADDR_VC_REMAP, 8'h1B, 8'hFF);
      u_qla_far_side.stall_q = 1'b0;
      for (int v = 0; v < 4; v++)
      begin
         send(1, {v[1:0], 6'h1E, 32'hDEAD0000 + v});
         exp_word({2'h1, 2'(3 - v), 6'h1E, 32'hDEAD0000 + v});
      end
      send(0, {2'h2, 6'h1F, 32'h12345678});
      exp_word({2'h0, 2'h2, 6'h1F, 32'h12345678});
      // RAW modes on port 2, sync held steady
      wr(ADDR_PORT_SELECT, 8'h02);
      for (int i = 0; i < 4; i++)
      begin
         wr(ADDR_PORT_CONFIGURATION, modes[i]);
         send(2, {26'h3FFF000, 2'b01, 12'hFFF});
         exp_word({2'h2, 2'h0, dts[i], 32'h1000 | masks[i]});
      end
      wr(ADDR_RAW_HEADER, 8'h9E);
      send(2, {26'h0, 2'b01, 12'hFFF});
      exp_word({2'h2, 2'h2, 6'h1E, 32'h10FF});
      // Fill the buffer from two ports while the sink stalls
      u_qla_far_side.stall_q = 1'b1;
      fork
         for (int k = 0; k < 8; k++)
            send(0, {2'h0, 6'h12, 32'(k)});
         for (int k = 0; k < 8; k++)
            send(1, {2'h0, 6'h12, 32'(k)});
      join
      fork
         send(2, {26'h0, 2'b01, 12'hABC});
      join_none
      repeat (20) @(negedge ref_clk);
      chk({41'h0, rx_ready[2]}, 42'h0, "full buffer refuses");
      rd_chk(ADDR_PORT_SELECT, 8'h02, 8'h03);
      u_qla_far_side.slow_q = 1'b1;
      u_qla_far_side.stall_q = 1'b0;
      for (int k = 0; k < 8; k++)
      begin
         exp_word({2'h0, 2'h0, 6'h12, 32'(k)});
         exp_word({2'h1, 2'h3, 6'h12, 32'(k)});
      end
      exp_word({2'h2, 2'h2, 6'h1E, 32'h10BC});
      repeat (3) @(negedge ref_clk);
      chk({41'h0, out_valid}, 42'h0, "buffer drained");
      // Second reset with a RAW10 strap
      do_reset(3'h3);
      rd_chk(ADDR_PORT_SELECT, {6'h0, RST_PORT_SELECT}, 8'h03);
      rd_chk(ADDR_PORT_CONFIGURATION, 8'h03, 8'h03);
      rd_chk(ADDR_BACK_CHANNEL_CONFIG, {5'h0, BC_SEL_2M5}, 8'h07);
      tick_chk(2, BC_DIV_2M5);
      // Port 0 in RAW10: a sync change too soon sets the status flag
      send(0, {26'h0, 2'b01, 12'h001});
      exp_word({2'h0, 2'h0, DT_RAW10, 32'h1001});
      send(0, {26'h0, 2'b10, 12'h002});
      exp_word({2'h0, 2'h0, DT_RAW10, 32'h2002});
      rd_chk(ADDR_PORT_STATUS, 8'h81, 8'h8F);
      wr(ADDR_PORT_STATUS, 8'h01);
      rd_chk(ADDR_PORT_STATUS, 8'h80, 8'h8F);
      wr(ADDR_PORT_CONFIGURATION, 8'h01);
      rd_chk(ADDR_PORT_CONFIGURATION, 8'h01, 8'h03);
      // Third reset with a non-synchronous packetized strap
      do_reset(3'h0);
      rd_chk(ADDR_BACK_CHANNEL_CONFIG, {5'h0, BC_SEL_10M}, 8'h07);
      tick_chk(1, BC_DIV_10M);
      end_sim();
   end
endmodule
